// ---- src/perg_record_gen.sv ----
// profiling event record generator: counts value samples, user instructions and
// near branches, and emits 32-byte records when a counter goes negative.
// assumes retire info and timestamp arrive on pclk; record writer handshakes rec_valid/rec_ready.
// Function
// RQ1: value sample decrements its counter; negative gives record code 1.
// RQ2: value record bytes 3..2 carry low 16 bits of immediate.
// RQ3: bytes 7..4 reg/mem operand; bytes 23..16 register, zero-extended in legacy mode.
// RQ4: value record bytes 15..8 hold the sampling instruction address.
// RQ5: bytes 31..24 timestamp when timestamp flag set, else zero.
// RQ6: byte 1 holds core id from the configuration register.
// RQ7: each retired instruction decrements counter; negative gives record code 2.
// RQ8: only instructions fully at privilege level 3 count.
// RQ9: instructions changing into level 3 do not count.
// RQ10: all user instructions count, profiler's own instructions included.
// RQ11: fused compare and branch counts as two instructions.
// RQ12: each retired transfer decrements branch counter; negative gives code 3.
// RQ13: near jumps, conditional, count-zero jumps, loops, near call and return count.
// RQ14: far transfers, traps and interrupts are not counted.
// RQ15: transfers entering or leaving ring 3, management or virtualization mode excluded.
// RQ16: fused branch sets fused flag and reports the compare address.
// RQ17: fused flag is bit 4 of byte 3.
// RQ18: taken flag is bit 7 of byte 3, always 1 when unconditional.
// RQ19: branch bytes 23..16 hold the address executed next.
// RQ20: reserved and undefined record fields are zero.
// RQ21: counter reloads with its interval after a record.
// RQ22: event code in byte 0; record leaves as one 32-byte unit.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module perg_record_gen
    import perg_pkg::*;
(
    input  wire logic          pclk,      // core clock, 200 MHz
    input  wire logic          presetn,   // async reset, active low
    input  wire logic          psel,      // apb select
    input  wire logic          penable,   // apb access phase
    input  wire logic          pwrite,    // apb direction
    input  wire logic [7:0]    paddr,     // apb byte address
    input  wire logic [31:0]   pwdata,    // apb write data
    output logic      [31:0]   prdata,    // apb read data
    output logic               pready,    // apb ready
    output logic               pslverr,   // apb error, unmapped address
    input  wire perg_pkg::perg_retire_t retire, // retirement info
    input  wire logic [63:0]   perf_ts,   // perf_timestamp_counter
    output perg_pkg::perg_record_t rec,   // event record
    output logic               rec_valid, // record offered
    input  wire logic          rec_ready  // writer takes record
);
    import perg_pkg::*;

    typedef struct packed {
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic               en;
        logic               ts_en;
        logic [7:0]         core_id;
        logic [2:0][31:0]   interval;
        logic               rec_valid;
        logic               rec_new;
        perg_record_t       rec;
        logic [31:0]        stored;
        logic [31:0]        missed;
    } perg_state_t;

    perg_state_t             s_r;
    perg_state_t             s_nxt;
    logic [NUM_EV-1:0]       fire;
    logic [NUM_EV-1:0][1:0]  dec;
    logic [NUM_EV-1:0][31:0] cnt;
    logic                    user_ok;
    logic                    br_counted;
    logic                    br_uncond;
    logic                    acc;
    logic                    slot_free;
    perg_record_t            r;

    always_comb begin
        // full user-mode execution, no ring or mode transition
        user_ok = retire.valid && retire.cpl_before == USER_CPL // RQ8
                  && retire.cpl_after == USER_CPL && !retire.mode_switch; // RQ9
        unique case (retire.br_kind)
            PERG_BR_JMP, PERG_BR_JCC, PERG_BR_JCXZ, PERG_BR_LOOP,
            PERG_BR_CALL, PERG_BR_RET: br_counted = 1'b1; // RQ13
            default:                   br_counted = 1'b0; // RQ14
        endcase
        br_uncond = retire.br_kind == PERG_BR_JMP || retire.br_kind == PERG_BR_CALL
                    || retire.br_kind == PERG_BR_RET;
        dec[IDX_VALUE]  = {1'b0, retire.valid & retire.val_sample}; // RQ1
        // value sample and event insert count like any user instruction
        dec[IDX_INSN]   = user_ok ? (retire.fused ? 2'h2 : 2'h1) : 2'h0; // RQ10 RQ11
        dec[IDX_BRANCH] = {1'b0, retire.valid && br_counted // RQ12
                          && retire.cpl_before == retire.cpl_after && !retire.mode_switch}; // RQ15
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EV; gi++) begin : g_cnt
            perg_evt_counter u_cnt (
                .pclk     (pclk),
                .presetn  (presetn),
                .load     (~s_r.en),
                .interval (s_r.interval[gi]),
                .dec      (dec[gi]),
                .count    (cnt[gi]),
                .fire     (fire[gi])
            );
        end
    endgenerate

    // record assembly; every field not set stays zero
    always_comb begin
        r         = '0; // RQ20
        r.core_id = s_r.core_id; // RQ6
        r.ts      = s_r.ts_en ? perf_ts : 64'h0; // RQ5
        r.iaddr   = retire.insn_addr; // RQ4 RQ16
        if (fire[IDX_VALUE]) begin
            r.code  = EV_VALUE; // RQ1
            r.flags = retire.imm; // RQ2
            r.sample_word_a = retire.regmem; // RQ3
            r.addr2 = retire.legacy_mode ? {32'h0, retire.reg_val[31:0]} : retire.reg_val; // RQ3
            // RQ4: iaddr is the sampling instruction itself
        end else if (fire[IDX_BRANCH]) begin
            r.code           = EV_BRANCH; // RQ12
            r.flags[FUS_BIT] = retire.fused; // RQ16 RQ17
            r.flags[TKN_BIT] = br_uncond | retire.taken; // RQ18
            r.addr2          = retire.next_addr; // RQ19
        end else begin
            r.code = EV_INSN; // RQ7
        end
    end

    always_comb begin
        s_nxt         = s_r;
        acc           = psel & penable;
        s_nxt.pready  = acc & ~s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = 32'h0;
        // read data and error registered on the same edge as pready
        if (acc && !s_r.pready) begin
            unique case (paddr)
                OFF_CTRL:      s_nxt.prdata = {16'h0, s_r.core_id, 6'h0, s_r.ts_en, s_r.en};
                OFF_IVL_VALUE: s_nxt.prdata = s_r.interval[IDX_VALUE];
                OFF_IVL_INSN:  s_nxt.prdata = s_r.interval[IDX_INSN];
                OFF_IVL_BR:    s_nxt.prdata = s_r.interval[IDX_BRANCH];
                OFF_CNT_VALUE: s_nxt.prdata = cnt[IDX_VALUE];
                OFF_CNT_INSN:  s_nxt.prdata = cnt[IDX_INSN];
                OFF_CNT_BR:    s_nxt.prdata = cnt[IDX_BRANCH];
                OFF_STORED:    s_nxt.prdata = s_r.stored;
                OFF_MISSED:    s_nxt.prdata = s_r.missed;
                default:       s_nxt.pslverr = 1'b1;
            endcase
            if (!pwrite) begin
                s_nxt.prdata = s_nxt.pslverr ? 32'h0 : s_nxt.prdata;
            end else begin
                s_nxt.prdata = 32'h0;
            end
        end
        // write commits on the edge that completes the access
        if (acc && s_r.pready && pwrite) begin
            unique case (paddr)
                OFF_CTRL: begin
                    s_nxt.en      = pwdata[CTRL_EN_BIT];
                    s_nxt.ts_en   = pwdata[CTRL_TS_BIT];
                    s_nxt.core_id = pwdata[CTRL_CORE_LSB +: 8];
                end
                OFF_IVL_VALUE: s_nxt.interval[IDX_VALUE]  = pwdata;
                OFF_IVL_INSN:  s_nxt.interval[IDX_INSN]   = pwdata;
                OFF_IVL_BR:    s_nxt.interval[IDX_BRANCH] = pwdata;
                OFF_STORED:    s_nxt.stored = 32'h0;
                OFF_MISSED:    s_nxt.missed = 32'h0;
                default:       s_nxt.missed = s_r.missed;
            endcase
        end

        // single record slot: held whole until the writer takes it
        s_nxt.rec_new = 1'b0;
        slot_free     = ~s_r.rec_valid | rec_ready;
        if (s_r.rec_valid && rec_ready) begin
            s_nxt.rec_valid = 1'b0;
        end
        if (|fire) begin
            if (slot_free) begin
                s_nxt.rec       = r; // RQ22
                s_nxt.rec_valid = 1'b1;
                s_nxt.rec_new   = 1'b1;
                s_nxt.stored    = s_r.stored + 32'h1;
                // simultaneous lower-priority underflows are lost
                s_nxt.missed    = s_r.missed + {30'h0, ({1'b0, fire[0]} + {1'b0, fire[1]}
                                  + {1'b0, fire[2]}) - 2'h1};
            end else begin
                s_nxt.missed    = s_r.missed + {30'h0, {1'b0, fire[0]} + {1'b0, fire[1]}
                                  + {1'b0, fire[2]}};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.interval <= {NUM_EV{RST_INTERVAL}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata    = s_r.prdata;
    assign pready    = s_r.pready;
    assign pslverr   = s_r.pslverr;
    assign rec       = s_r.rec;
    assign rec_valid = s_r.rec_valid;

    value_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        $past(fire[IDX_VALUE]) && $past(slot_free) |-> s_r.rec_new && s_r.rec.code == EV_VALUE)
        else $error("value sample underflow gave no code 1 record");

    imm_field_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        s_r.rec_new && s_r.rec.code == EV_VALUE |-> s_r.rec.flags == $past(retire.imm))
        else $error("value record immediate wrong");

    value_data_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        s_r.rec_new && s_r.rec.code == EV_VALUE |-> s_r.rec.sample_word_a == $past(retire.regmem)
        && s_r.rec.addr2 == ($past(retire.legacy_mode) ? {32'h0, $past(retire.reg_val[31:0])}
        : $past(retire.reg_val)))
        else $error("value record operands wrong");

    value_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        s_r.rec_new |-> s_r.rec.iaddr == $past(retire.insn_addr))
        else $error("record instruction address wrong");

    stamp_field_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        s_r.rec_new |-> s_r.rec.ts == ($past(s_r.ts_en) ? $past(perf_ts) : 64'h0))
        else $error("timestamp field wrong");

    core_field_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        s_r.rec_new |-> s_r.rec.core_id == $past(s_r.core_id))
        else $error("core id field wrong");

    insn_user_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        s_r.rec_new && s_r.rec.code == EV_INSN |-> $past(retire.cpl_before) == USER_CPL
        && $past(retire.cpl_after) == USER_CPL)
        else $error("non-user instruction produced a retired record");

    branch_fused_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
        s_r.rec_new && s_r.rec.code == EV_BRANCH |-> s_r.rec.flags[FUS_BIT] == $past(retire.fused)
        && s_r.rec.addr2 == $past(retire.next_addr))
        else $error("branch fused flag or target wrong");

    branch_taken_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
        s_r.rec_new && s_r.rec.code == EV_BRANCH && $past(br_uncond) |-> s_r.rec.flags[TKN_BIT])
        else $error("unconditional branch not marked taken");

    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
        s_r.rec_new && s_r.rec.code == EV_INSN |-> s_r.rec.flags == 16'h0
        && s_r.rec.sample_word_a == 32'h0 && s_r.rec.addr2 == 64'h0)
        else $error("reserved field not zero");

    record_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
        s_r.rec_valid && !rec_ready |=> s_r.rec_valid && $stable(s_r.rec))
        else $error("record changed before writer took it");

    insn_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        $past(fire) == 3'h2 && $past(slot_free) |-> s_r.rec_new && s_r.rec.code == EV_INSN)
        else $error("instruction underflow gave no code 2 record");

    entry_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        retire.cpl_before != USER_CPL |-> dec[IDX_INSN] == 2'h0)
        else $error("instruction entering user level was counted");

    user_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        retire.valid && retire.cpl_before == USER_CPL && retire.cpl_after == USER_CPL
        && !retire.mode_switch && !retire.fused |-> dec[IDX_INSN] == 2'h1)
        else $error("user instruction not counted once");

    fused_double_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        retire.valid && retire.cpl_before == USER_CPL && retire.cpl_after == USER_CPL
        && !retire.mode_switch && retire.fused |-> dec[IDX_INSN] == 2'h2)
        else $error("fused pair not counted as two");

    branch_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        $past(fire[IDX_BRANCH]) && !$past(fire[IDX_VALUE]) && $past(slot_free)
        |-> s_r.rec_new && s_r.rec.code == EV_BRANCH)
        else $error("branch underflow gave no code 3 record");

    near_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        retire.valid && retire.br_kind inside {PERG_BR_JMP, PERG_BR_JCC, PERG_BR_JCXZ, PERG_BR_LOOP,
        PERG_BR_CALL, PERG_BR_RET} && retire.cpl_before == retire.cpl_after && !retire.mode_switch
        |-> dec[IDX_BRANCH] == 2'h1)
        else $error("near transfer not counted");

    far_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
        retire.br_kind inside {PERG_BR_FAR, PERG_BR_TRAP, PERG_BR_INTR, PERG_BR_SYS} |-> dec[IDX_BRANCH] == 2'h0)
        else $error("far transfer or trap counted");

    ring_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        retire.cpl_before != retire.cpl_after || retire.mode_switch |-> dec[IDX_BRANCH] == 2'h0)
        else $error("ring or mode change counted as branch");

    fused_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        s_r.rec_new && s_r.rec.code == EV_BRANCH |-> s_r.rec.iaddr == $past(retire.insn_addr))
        else $error("branch record address wrong");

    target_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
        s_r.rec_new && s_r.rec.code == EV_BRANCH |-> s_r.rec.addr2 == $past(retire.next_addr))
        else $error("branch next address wrong");

    branch_reserved_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
        s_r.rec_new && s_r.rec.code == EV_BRANCH |-> s_r.rec.flags[11:0] == 12'h0
        && s_r.rec.flags[14:13] == 2'h0 && s_r.rec.sample_word_a == 32'h0)
        else $error("branch reserved field not zero");

    record_code_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
        s_r.rec_valid |-> s_r.rec.code != 8'h0)
        else $error("record offered with empty event code");

    error_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.pslverr |-> s_r.pready)
        else $error("apb error without ready");
endmodule
`default_nettype wire

// ---- src/perg_pkg.sv ----
// package for the profiling event record generator: map, field positions, carriers
// assumes one core clock domain shared by retirement logic, record writer and apb
package perg_pkg;
    localparam int NUM_EV = 3;

    // event slots of the counter bank
    localparam int IDX_VALUE  = 0;
    localparam int IDX_INSN   = 1;
    localparam int IDX_BRANCH = 2;

    // event codes placed in byte 0
    localparam logic [7:0] EV_VALUE  = 8'h01;
    localparam logic [7:0] EV_INSN   = 8'h02;
    localparam logic [7:0] EV_BRANCH = 8'h03;

    localparam logic [1:0] USER_CPL = 2'h3;

    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_IVL_VALUE = 8'h04;
    localparam logic [7:0] OFF_IVL_INSN  = 8'h08;
    localparam logic [7:0] OFF_IVL_BR    = 8'h0c;
    localparam logic [7:0] OFF_CNT_VALUE = 8'h10;
    localparam logic [7:0] OFF_CNT_INSN  = 8'h14;
    localparam logic [7:0] OFF_CNT_BR    = 8'h18;
    localparam logic [7:0] OFF_STORED    = 8'h1c;
    localparam logic [7:0] OFF_MISSED    = 8'h20;

    // profiler_config_reg layout
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_TS_BIT   = 1;
    localparam int CTRL_CORE_LSB = 8;

    // flag positions inside the 16-bit flags field (bytes 3..2)
    localparam int FUS_BIT = 12;
    localparam int TKN_BIT = 15;

    localparam logic [31:0] RST_INTERVAL = 32'h0000_ffff;
    localparam logic [31:0] RST_COUNT    = 32'h0000_0000;

    typedef enum logic [3:0] {
        PERG_BR_NONE  = 4'h0,
        PERG_BR_JMP   = 4'h1,
        PERG_BR_JCC   = 4'h2,
        PERG_BR_JCXZ  = 4'h3,
        PERG_BR_LOOP  = 4'h4,
        PERG_BR_CALL  = 4'h5,
        PERG_BR_RET   = 4'h6,
        PERG_BR_FAR   = 4'h7,
        PERG_BR_TRAP  = 4'h8,
        PERG_BR_INTR  = 4'h9,
        PERG_BR_SYS   = 4'ha
    } perg_br_kind_t;

    typedef struct packed {
        logic          valid;       // one retired instruction this cycle
        logic [1:0]    cpl_before;  // current_privilege_level at start
        logic [1:0]    cpl_after;   // current_privilege_level at end
        logic          mode_switch; // enters or leaves system_mgmt_mode or virtualization_mode
        logic          val_sample;  // value_sample_insn
        perg_br_kind_t br_kind;
        logic          fused;       // compare fused with following branch
        logic          taken;
        logic          legacy_mode;
        logic [63:0]   insn_addr;   // compare address when fused
        logic [63:0]   next_addr;
        logic [15:0]   imm;
        logic [31:0]   regmem;
        logic [63:0]   reg_val;
    } perg_retire_t;

    // byte 31 at the top, byte 0 at the bottom
    typedef struct packed {
        logic [63:0] ts;
        logic [63:0] addr2;
        logic [63:0] iaddr;
        logic [31:0] sample_word_a;
        logic [15:0] flags;
        logic [7:0]  core_id;
        logic [7:0]  code;
    } perg_record_t;

    typedef struct packed {
        logic [31:0] count;
    } perg_cnt_state_t;
endpackage

// ---- src/perg_evt_counter.sv ----
// one event down-counter with reload on underflow
// assumes dec and load come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module perg_evt_counter
    import perg_pkg::*;
(
    input  wire logic        pclk,     // core clock
    input  wire logic        presetn,  // async reset, active low
    input  wire logic        load,     // hold at interval
    input  wire logic [31:0] interval, // sampling interval
    input  wire logic [1:0]  dec,      // occurrences this cycle
    output logic      [31:0] count,    // current value
    output logic             fire      // counter went negative
);
    perg_cnt_state_t s_r;
    perg_cnt_state_t s_nxt;
    logic [32:0]     diff;

    always_comb begin
        diff  = {1'b0, s_r.count} - {31'h0, dec};
        fire  = ~load & diff[32];
        s_nxt = s_r;
        if (load || fire) begin
            s_nxt.count = interval; // RQ21
        end else begin
            s_nxt.count = diff[31:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.count <= RST_COUNT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.count;

    reload_after_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
        fire |=> s_r.count == $past(interval))
        else $error("counter not reloaded after underflow");
endmodule
`default_nettype wire

// ---- bench/perg_core_model.sv ----
// retirement-side model: one retired instruction per send call, free-running timestamp
// assumes send is called right after a rising edge of pclk
`timescale 1ns/10ps
`default_nettype none
module perg_core_model
    import perg_pkg::*;
(
    input  wire logic              pclk,    // core clock
    input  wire logic              presetn, // async reset, active low
    output perg_pkg::perg_retire_t retire,  // retirement info
    output logic [63:0]            perf_ts  // perf_timestamp_counter
);
    initial begin
        retire = '0;
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            perf_ts <= 64'h0000_0100_0000_0000;
        else
            perf_ts <= perf_ts + 64'h1;
    end
    task automatic send(input perg_retire_t r, output logic [63:0] ts);
        perg_retire_t idle;
        retire <= r;
        @(posedge pclk);
        ts = perf_ts;
        // idle cycles show inverted fields so stale data is never mistaken for fresh
        idle = perg_retire_t'(~r);
        idle.valid = 1'b0;
        retire <= idle;
        // one idle cycle so back-to-back calls never assign retire twice in one step
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_perg_record_gen.sv ----
// self-checking bench for the record generator: apb setup, retirement stimulus, record checks
// assumes one 200 MHz clock and the retirement model beside the design
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin mismatches++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end
module tb_perg_record_gen;
    import perg_pkg::*;
    localparam logic [41:0] TBL = {6'h3c, 6'h3c, 6'h3d, 6'h3e, 6'h30, 6'h00, 6'h0c};
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, rec_valid, rec_ready, err;
    logic [7:0]   paddr, core;
    logic [31:0]  pwdata, prdata, q, ctl;
    logic [63:0]  perf_ts, ts;
    perg_retire_t retire, r;
    perg_record_t rec, e1;
    perg_br_kind_t kind;
    int           mismatches, n_tests, cyc, seed;
    perg_record_gen perg_record_gen_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .retire(retire), .perf_ts(perf_ts), .rec(rec), .rec_valid(rec_valid), .rec_ready(rec_ready));
    perg_core_model perg_core_model_inst (.pclk(pclk), .presetn(presetn), .retire(retire), .perf_ts(perf_ts));
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // waits for pready; only the global cycle ceiling ends a wait that pready never ends
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] ex, input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", ex, q)
        `CHK("pslverr", ee, err)
    endtask
    task automatic cfg(input logic [31:0] c, input logic [31:0] iv, input logic [31:0] ii, input logic [31:0] ib);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_IVL_VALUE, iv);
        apb(1'b1, OFF_IVL_INSN, ii);
        apb(1'b1, OFF_IVL_BR, ib);
        apb(1'b1, OFF_CTRL, c);
        ctl = c;
    endtask
    function automatic perg_retire_t rnd(input logic vs, input perg_br_kind_t k, input logic [5:0] pm);
        perg_retire_t x;
        x = '0;
        {x.valid, x.cpl_before, x.cpl_after, x.mode_switch, x.fused} = {1'b1, pm};
        x.val_sample = vs;
        x.br_kind = k;
        x.taken = 1'($urandom);
        x.legacy_mode = 1'($urandom);
        x.insn_addr = {$urandom, $urandom};
        x.next_addr = {$urandom, $urandom};
        x.imm = 16'($urandom);
        x.regmem = $urandom;
        x.reg_val = {$urandom, $urandom};
        return x;
    endfunction
    function automatic perg_record_t exp_rec(input logic [7:0] c, input perg_retire_t x, input logic [63:0] t);
        perg_record_t e;
        e = '0;
        e.code = c;
        e.core_id = ctl[15:8];
        e.iaddr = x.insn_addr;
        if (ctl[1])
            e.ts = t;
        if (c == EV_VALUE) begin
            e.flags = x.imm;
            e.sample_word_a = x.regmem;
            e.addr2 = x.legacy_mode ? {32'h0, x.reg_val[31:0]} : x.reg_val;
        end
        if (c == EV_BRANCH) begin
            e.flags[FUS_BIT] = x.fused;
            e.flags[TKN_BIT] = x.taken | (x.br_kind inside {PERG_BR_JMP, PERG_BR_CALL, PERG_BR_RET});
            e.addr2 = x.next_addr;
        end
        return e;
    endfunction
    task automatic chk_rec(input perg_record_t e);
        @(posedge pclk);
        `CHK("rec_valid", 1'b1, rec_valid)
        `CHK("rec", e, rec)
        rec_ready <= 1'b1;
        @(posedge pclk);
        rec_ready <= 1'b0;
    endtask
    task automatic no_rec();
        @(posedge pclk);
        `CHK("rec_valid", 1'b0, rec_valid)
    endtask
    task automatic vsend();
        r = rnd(1'b1, PERG_BR_NONE, 6'h3c);
        perg_core_model_inst.send(r, ts);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, rec_ready, paddr, pwdata} = '0;
        seed = $urandom(64);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rreg(OFF_CTRL, 32'h0, 1'b0);
        rreg(OFF_IVL_VALUE, RST_INTERVAL, 1'b0);
        rreg(8'h24, 32'h0, 1'b1);
        apb(1'b1, 8'h24, 32'hffff_ffff);
        `CHK("pslverr", 1'b1, err)
        rreg(OFF_CTRL, 32'h0, 1'b0);
        $display("test reset done");
        core = 8'($urandom);
        cfg({16'h0, core, 8'h03}, 32'h1, RST_INTERVAL, RST_INTERVAL);
        for (int i = 0; i < 4; i++) begin
            vsend();
            if (i[0])
                chk_rec(exp_rec(EV_VALUE, r, ts));
            else
                no_rec();
        end
        // slot left full so the next underflow is lost
        repeat (2) vsend();
        e1 = exp_rec(EV_VALUE, r, ts);
        repeat (2) vsend();
        rreg(OFF_MISSED, 32'h1, 1'b0);
        rreg(OFF_STORED, 32'h3, 1'b0);
        apb(1'b1, OFF_MISSED, 32'h5);
        `CHK("pslverr", 1'b0, err)
        rreg(OFF_MISSED, 32'h0, 1'b0);
        chk_rec(e1);
        $display("test value sample done");
        cfg({16'h0, core, 8'h01}, RST_INTERVAL, 32'h3, RST_INTERVAL);
        rreg(OFF_CNT_INSN, 32'h3, 1'b0);
        for (int i = 0; i < 7; i++) begin
            r = rnd(i == 5, TBL[i*6] ? PERG_BR_JCC : PERG_BR_NONE, TBL[i*6 +: 6]);
            perg_core_model_inst.send(r, ts);
            if (i == 6)
                chk_rec(exp_rec(EV_INSN, r, ts));
            else
                no_rec();
        end
        rreg(OFF_CNT_INSN, 32'h3, 1'b0);
        $display("test retired instructions done");
        cfg({16'h0, core, 8'h03}, RST_INTERVAL, RST_INTERVAL, 32'h0);
        for (int k = 0; k < 13; k++) begin
            kind = perg_br_kind_t'(k < 11 ? k : (k == 11 ? 1 : 5));
            r = rnd(1'b0, kind, k == 11 ? 6'h30 : (k == 12 ? 6'h3e : {5'h1e, 1'($urandom) & (k == 2)}));
            perg_core_model_inst.send(r, ts);
            if (k >= 1 && k <= 6)
                chk_rec(exp_rec(EV_BRANCH, r, ts));
            else
                no_rec();
        end
        $display("test branches done");
        end_sim();
    end
endmodule
`default_nettype wire
